// ===== bsid_pkg.sv
// bsid_pkg: shared types and constants of the borrow-subtract / inc / dec / clear datapath
// assumes one core clock domain; the decoder presents one operation per cycle
package bsid_pkg;

    localparam int unsigned DATA_W = 8;

    localparam logic [7:0] WORK_RST  = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // operations the decoder can request
    typedef enum logic [2:0] {
        BSID_OP_NONE,
        BSID_OP_SUBC_AM,
        BSID_OP_SUBC_MA,
        BSID_OP_SUBC_A,
        BSID_OP_SUBC_M,
        BSID_OP_INC_M,
        BSID_OP_DEC_M,
        BSID_OP_CLR_M
    } bsid_op_t;

    // arithmetic flags
    typedef struct packed {
        logic null_bit;
        logic borrow_bit;
        logic nibble_borrow_bit;
        logic signed_wrap_bit;
    } bsid_flags_t;

    // request from the decoder
    typedef struct packed {
        logic       valid;
        bsid_op_t   op;
        logic [7:0] mem_data;
    } bsid_req_t;

    // write-back toward data memory
    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } bsid_mem_wr_t;

endpackage

// ===== bsid_alu.sv
// bsid_alu: borrow-subtract, increment, decrement and clear datapath slice
// assumes the decoder holds mem_data valid with req.valid; memory write happens one cycle later
`timescale 1ns/1ps

// Behaviour
// (RQ1) subtract-with-borrow into work register: work minus memory minus borrow
// (RQ2) subtract-with-borrow into memory: memory minus work minus borrow
// (RQ3) single-operand on work register: work minus borrow into work register
// (RQ4) single-operand on memory: memory minus borrow written back to memory
// (RQ5) increment adds one to memory byte and writes it back
// (RQ6) decrement subtracts one from memory byte and writes it back
// (RQ7) clear writes zero into memory byte
// (RQ8) borrow-subtract, increment and decrement update all four flags from result
// (RQ9) borrow from bit 7, nibble borrow from bit 3, signed wrap on overflow
module bsid_alu (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire bsid_pkg::bsid_req_t  req,
    output logic [7:0]                work_register,
    output bsid_pkg::bsid_flags_t     flags,
    output bsid_pkg::bsid_mem_wr_t    mem_wr
);

    typedef struct packed {
        logic [7:0]             work;
        bsid_pkg::bsid_flags_t  flg;
        bsid_pkg::bsid_mem_wr_t mw;
    } bsid_state_t;

    bsid_state_t s_q;
    bsid_state_t s_d;

    logic [7:0] opa;
    logic [7:0] opb;
    logic       cin;
    logic       is_add;
    logic       upd_flags;
    logic       to_mem;
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] res;

    always_comb begin
        opa       = 8'h00;
        opb       = 8'h00;
        cin       = 1'b0;
        is_add    = 1'b0;
        upd_flags = 1'b0;
        to_mem    = 1'b0;
        unique case (req.op)
            bsid_pkg::BSID_OP_NONE: begin
            end
            bsid_pkg::BSID_OP_SUBC_AM: begin
                opa       = s_q.work; // RQ1
                opb       = req.mem_data;
                cin       = s_q.flg.borrow_bit;
                upd_flags = 1'b1;
            end
            bsid_pkg::BSID_OP_SUBC_MA: begin
                opa       = req.mem_data; // RQ2
                opb       = s_q.work;
                cin       = s_q.flg.borrow_bit;
                upd_flags = 1'b1;
                to_mem    = 1'b1;
            end
            bsid_pkg::BSID_OP_SUBC_A: begin
                opa       = s_q.work; // RQ3
                cin       = s_q.flg.borrow_bit;
                upd_flags = 1'b1;
            end
            bsid_pkg::BSID_OP_SUBC_M: begin
                opa       = req.mem_data; // RQ4
                cin       = s_q.flg.borrow_bit;
                upd_flags = 1'b1;
                to_mem    = 1'b1;
            end
            bsid_pkg::BSID_OP_INC_M: begin
                opa       = req.mem_data; // RQ5
                opb       = 8'h01;
                is_add    = 1'b1;
                upd_flags = 1'b1;
                to_mem    = 1'b1;
            end
            bsid_pkg::BSID_OP_DEC_M: begin
                opa       = req.mem_data; // RQ6
                opb       = 8'h01;
                upd_flags = 1'b1;
                to_mem    = 1'b1;
            end
            bsid_pkg::BSID_OP_CLR_M: begin
                to_mem    = 1'b1; // RQ7
            end
        endcase
    end

    always_comb begin
        if (is_add) begin
            full = {1'b0, opa} + {1'b0, opb};
            low  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
        end else begin
            full = {1'b0, opa} - {1'b0, opb} - {8'h00, cin}; // RQ9
            low  = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin}; // RQ9
        end
        res = (req.op == bsid_pkg::BSID_OP_CLR_M) ? 8'h00 : full[7:0];
    end

    always_comb begin
        s_d        = s_q;
        s_d.mw.wr  = 1'b0;
        if (req.valid) begin
            if (upd_flags) begin
                s_d.flg.null_bit          = (full[7:0] == 8'h00); // RQ8
                s_d.flg.borrow_bit        = full[8]; // RQ9
                s_d.flg.nibble_borrow_bit = low[4]; // RQ9
                s_d.flg.signed_wrap_bit   = is_add ? (opa[7] == opb[7]) && (full[7] != opa[7])
                                                   : (opa[7] != opb[7]) && (full[7] != opa[7]); // RQ9
            end
            if (to_mem) begin
                s_d.mw.wr   = 1'b1;
                s_d.mw.data = res;
            end else if (req.op != bsid_pkg::BSID_OP_NONE) begin
                s_d.work = res;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.work <= bsid_pkg::WORK_RST;
            s_q.flg  <= bsid_pkg::FLAGS_RST;
            s_q.mw   <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign work_register = s_q.work;
    assign flags         = s_q.flg;
    assign mem_wr        = s_q.mw;

    property p_subc_am;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_SUBC_AM) |=>
            work_register == 8'($past(s_q.work) - $past(req.mem_data) - {7'h00, $past(s_q.flg.borrow_bit)});
    endproperty
    a_subc_am: assert property (p_subc_am) else $error("subc work,mem result wrong"); // RQ1

    property p_subc_ma;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_SUBC_MA) |=> mem_wr.wr &&
            mem_wr.data == 8'($past(req.mem_data) - $past(s_q.work) - {7'h00, $past(s_q.flg.borrow_bit)});
    endproperty
    a_subc_ma: assert property (p_subc_ma) else $error("subc mem,work result wrong"); // RQ2

    property p_subc_a;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_SUBC_A) |=>
            work_register == 8'($past(s_q.work) - {7'h00, $past(s_q.flg.borrow_bit)}) && !mem_wr.wr;
    endproperty
    a_subc_a: assert property (p_subc_a) else $error("subc work result wrong"); // RQ3

    property p_subc_m;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_SUBC_M) |=> mem_wr.wr &&
            mem_wr.data == 8'($past(req.mem_data) - {7'h00, $past(s_q.flg.borrow_bit)}) && $stable(work_register);
    endproperty
    a_subc_m: assert property (p_subc_m) else $error("subc mem result wrong"); // RQ4

    property p_subc_m_flags;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_SUBC_M) |=>
            flags.borrow_bit == ($past(flags.borrow_bit) && $past(req.mem_data) == 8'h00) &&
            flags.signed_wrap_bit == ($past(flags.borrow_bit) && $past(req.mem_data) == 8'h80);
    endproperty
    a_subc_m_flags: assert property (p_subc_m_flags) else $error("subc mem borrow or wrap flag wrong"); // RQ9

    property p_inc;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_INC_M) |=>
            mem_wr.wr && mem_wr.data == 8'($past(req.mem_data) + 8'h01);
    endproperty
    a_inc: assert property (p_inc) else $error("increment result wrong"); // RQ5

    property p_dec;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_DEC_M) |=>
            mem_wr.wr && mem_wr.data == 8'($past(req.mem_data) - 8'h01);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement result wrong"); // RQ6

    property p_clr;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_CLR_M) |=> mem_wr.wr && mem_wr.data == 8'h00 && $stable(flags);
    endproperty
    a_clr: assert property (p_clr) else $error("clear result wrong"); // RQ7

    property p_null;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && upd_flags) |=>
            flags.null_bit == ($past(to_mem) ? (mem_wr.data == 8'h00) : (work_register == 8'h00));
    endproperty
    a_null: assert property (p_null) else $error("null flag does not match result"); // RQ8

    property p_borrow;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && !is_add && upd_flags && req.op == bsid_pkg::BSID_OP_DEC_M) |=>
            flags.borrow_bit == ($past(req.mem_data) == 8'h00) &&
            flags.nibble_borrow_bit == ($past(req.mem_data[3:0]) == 4'h0);
    endproperty
    a_borrow: assert property (p_borrow) else $error("decrement borrow flags wrong"); // RQ9

    property p_wrap;
        @(posedge sys_clk) disable iff (!rst_n)
        (req.valid && req.op == bsid_pkg::BSID_OP_INC_M) |=> flags.signed_wrap_bit == ($past(req.mem_data) == 8'h7f);
    endproperty
    a_wrap: assert property (p_wrap) else $error("increment signed wrap wrong"); // RQ9

    property p_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        !req.valid |=> !mem_wr.wr ##0 $stable(flags);
    endproperty
    a_idle: assert property (p_idle) else $error("state changed without a request");

endmodule

// ===== bsid_ram_model.sv
// bsid_ram_model: decoder and data ram stand-in for the datapath
// assumes the bench drives commands shortly after the clock edge
`timescale 1ns/1ps
module bsid_ram_model (
    input  wire logic                   sys_clk,
    input  wire logic                   cmd_valid,
    input  wire bsid_pkg::bsid_op_t     cmd_op,
    input  wire logic [1:0]             cmd_addr,
    input  wire logic                   load_en,
    input  wire logic [7:0]             load_data,
    input  wire bsid_pkg::bsid_mem_wr_t mem_wr,
    output bsid_pkg::bsid_req_t         req
);
    logic [7:0] mem [4];
    logic [1:0] wr_addr_q;
    logic [7:0] last_q = 8'h5a;
    always_comb begin
        req.valid    = cmd_valid;
        req.op       = cmd_op;
        req.mem_data = cmd_valid ? mem[cmd_addr] : ~last_q; // idle bus toggles
    end
    always_ff @(posedge sys_clk) begin
        if (load_en) mem[cmd_addr] <= load_data;
        if (mem_wr.wr) mem[wr_addr_q] <= mem_wr.data;
        if (cmd_valid) wr_addr_q <= cmd_addr;
        last_q <= req.mem_data;
    end
endmodule

// ===== tb.sv
// tb: self-checking bench of the borrow-subtract datapath
// assumes results just after the taking edge, checked 5 ns later
`timescale 1ns/1ps
module tb;
    logic                   sys_clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic                   cmd_valid = 1'b0;
    logic                   load_en = 1'b0;
    bsid_pkg::bsid_op_t     cmd_op = bsid_pkg::BSID_OP_NONE;
    logic [1:0]             cmd_addr = 2'h0;
    logic [7:0]             load_data = 8'h00;
    bsid_pkg::bsid_req_t    req;
    logic [7:0]             work_register;
    bsid_pkg::bsid_flags_t  flags;
    bsid_pkg::bsid_mem_wr_t mem_wr;
    int                     mismatches = 0;
    int                     checks_done = 0;
    logic [7:0]             exp_mem [4];
    logic [7:0]             exp_work = 8'h00;
    bsid_pkg::bsid_flags_t  exp_flags = 4'h0;
    bsid_alu dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .work_register(work_register), .flags(flags),
        .mem_wr(mem_wr));
    bsid_ram_model ram (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .load_en(load_en), .load_data(load_data), .mem_wr(mem_wr), .req(req));
    always #25 sys_clk = ~sys_clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task load(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk) #5 cmd_addr = a;
        load_data = d;
        load_en = 1'b1;
        @(posedge sys_clk) #5 load_en = 1'b0;
        exp_mem[a] = d;
    endtask
    task op(input bsid_pkg::bsid_op_t o, input logic [1:0] a);
        logic [8:0] d;
        logic [4:0] n;
        logic [7:0] x, y;
        logic c, mw;
        bsid_pkg::bsid_flags_t f;
        x = exp_mem[a];
        y = 8'h00;
        c = exp_flags.borrow_bit;
        mw = 1'b1;
        case (o)
            bsid_pkg::BSID_OP_SUBC_AM: begin y = x; x = exp_work; mw = 1'b0; end
            bsid_pkg::BSID_OP_SUBC_MA: y = exp_work;
            bsid_pkg::BSID_OP_SUBC_A: begin x = exp_work; mw = 1'b0; end
            bsid_pkg::BSID_OP_DEC_M: begin y = 8'h01; c = 1'b0; end
            bsid_pkg::BSID_OP_SUBC_M: ;
            default: c = 1'b0;
        endcase
        d = {1'b0, x} - {1'b0, y} - {8'h00, c};
        n = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, c};
        f = {d[7:0] == 8'h00, d[8], n[4], (x[7] != y[7]) && (d[7] != x[7])};
        if (o == bsid_pkg::BSID_OP_INC_M) begin
            d = {1'b0, x} + 9'h001;
            n = {1'b0, x[3:0]} + 5'h01;
            f = {d[7:0] == 8'h00, d[8], n[4], x == 8'h7f};
        end
        if (o == bsid_pkg::BSID_OP_CLR_M) begin
            d = 9'h000;
            f = exp_flags;
        end
        @(posedge sys_clk) #5 cmd_valid = 1'b1;
        cmd_op = o;
        cmd_addr = a;
        @(posedge sys_clk) #5 cmd_valid = 1'b0;
        if (mw) exp_mem[a] = d[7:0];
        else exp_work = d[7:0];
        exp_flags = f;
        chk({7'h00, mem_wr.wr}, {7'h00, mw});
        if (mw) chk(mem_wr.data, d[7:0]);
        chk(work_register, exp_work);
        chk({4'h0, flags}, {4'h0, exp_flags});
    endtask
    task print_verdict;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task t_reset;
        chk(work_register, 8'h00);
        chk({4'h0, flags}, 8'h00);
        chk({7'h00, mem_wr.wr}, 8'h00);
        chk(mem_wr.data, 8'h00);
        $display("test reset done");
    endtask
    task t_subc;
        load(2'h0, 8'h34);
        load(2'h1, 8'h12);
        load(2'h2, 8'h80);
        op(bsid_pkg::BSID_OP_SUBC_AM, 2'h0);
        op(bsid_pkg::BSID_OP_SUBC_MA, 2'h1);
        op(bsid_pkg::BSID_OP_SUBC_M, 2'h2);
        op(bsid_pkg::BSID_OP_SUBC_A, 2'h0);
        op(bsid_pkg::BSID_OP_SUBC_MA, 2'h0);
        op(bsid_pkg::BSID_OP_SUBC_A, 2'h0);
        load(2'h0, 8'hcb);
        op(bsid_pkg::BSID_OP_SUBC_MA, 2'h0);
        $display("test subc done");
    endtask
    task t_chain;
        load(2'h0, 8'h00);
        load(2'h1, 8'h01);
        @(posedge sys_clk) #5 cmd_valid = 1'b1;
        cmd_op = bsid_pkg::BSID_OP_SUBC_M;
        cmd_addr = 2'h0;
        @(posedge sys_clk) #5 cmd_addr = 2'h1;
        chk(mem_wr.data, 8'hff);
        chk({4'h0, flags}, 8'h06);
        @(posedge sys_clk) #5 cmd_valid = 1'b0;
        chk({7'h00, mem_wr.wr}, 8'h01);
        chk(mem_wr.data, 8'h00);
        chk({4'h0, flags}, 8'h08);
        exp_mem[0] = 8'hff;
        exp_mem[1] = 8'h00;
        exp_flags = 4'h8;
        $display("test borrow chain done");
    endtask
    task t_rst_mid;
        @(posedge sys_clk) #5 rst_n = 1'b0;
        @(posedge sys_clk) #5 chk(work_register, 8'h00);
        chk({4'h0, flags}, 8'h00);
        chk({7'h00, mem_wr.wr}, 8'h00);
        rst_n = 1'b1;
        exp_work = 8'h00;
        exp_flags = 4'h0;
        op(bsid_pkg::BSID_OP_SUBC_A, 2'h0);
        $display("test mid-run reset done");
    endtask
    task t_incdec;
        load(2'h3, 8'hff);
        op(bsid_pkg::BSID_OP_INC_M, 2'h3);
        op(bsid_pkg::BSID_OP_INC_M, 2'h3);
        op(bsid_pkg::BSID_OP_INC_M, 2'h2);
        op(bsid_pkg::BSID_OP_DEC_M, 2'h2);
        op(bsid_pkg::BSID_OP_DEC_M, 2'h3);
        op(bsid_pkg::BSID_OP_DEC_M, 2'h3);
        $display("test incdec done");
    endtask
    task t_clear;
        op(bsid_pkg::BSID_OP_CLR_M, 2'h1);
        @(posedge sys_clk) #5 cmd_op = bsid_pkg::BSID_OP_SUBC_AM;
        @(posedge sys_clk) #5 chk({7'h00, mem_wr.wr}, 8'h00);
        chk(work_register, exp_work);
        chk({4'h0, flags}, {4'h0, exp_flags});
        cmd_valid = 1'b1;
        cmd_op = bsid_pkg::BSID_OP_NONE;
        @(posedge sys_clk) #5 cmd_valid = 1'b0;
        chk({7'h00, mem_wr.wr}, 8'h00);
        chk(work_register, exp_work);
        chk({4'h0, flags}, {4'h0, exp_flags});
        $display("test clear and idle done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        #5 rst_n = 1'b1;
        t_reset();
        t_subc();
        t_incdec();
        t_chain();
        t_rst_mid();
        t_clear();
        print_verdict();
    end
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule
